// ===== hw/compare_pwm_pkg.sv
/*
  Constants of the compare/PWM unit: register offsets, field positions,
  reset values and widths. Assumes a 32-bit AXI4-Lite slave with byte offsets.
*/
package compare_pwm_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned FAST_CH = 8;
  localparam int unsigned GEN_CH = 2;
  localparam int unsigned PRE_W = 7;
  // Register byte offsets
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_ASSIGN = 8'h04;
  localparam logic [7:0] OFF_OUT_EN = 8'h08;
  localparam logic [7:0] OFF_RELOAD_LOW = 8'h0c;
  localparam logic [7:0] OFF_RELOAD_HIGH = 8'h10;
  localparam logic [7:0] OFF_CT_COUNT = 8'h14;
  localparam logic [7:0] OFF_GT_COUNT = 8'h18;
  localparam logic [7:0] OFF_GEN_CFG = 8'h1c;
  localparam logic [7:0] OFF_FLAGS = 8'h20;
  localparam logic [7:0] OFF_GC_BASE = 8'h24;
  localparam logic [7:0] OFF_FAST_BASE = 8'h40;
  // Control fields
  localparam int unsigned CTL_PRESCALE_LSB = 0;
  localparam int unsigned CTL_CT_RUN = 3;
  localparam int unsigned CTL_CT_IRQ_EN = 4;
  localparam int unsigned CTL_GLOBAL_IRQ_EN = 5;
  localparam int unsigned CTL_GT_RUN = 6;
  // General channel config fields: mode, irq enable, port latch
  localparam int unsigned GEN_MODE_LSB = 0;
  localparam int unsigned GEN_IRQ_EN_LSB = 2;
  localparam int unsigned GEN_LATCH_LSB = 4;
  // Flag fields
  localparam int unsigned FLAG_CT_OVF = 0;
  localparam int unsigned FLAG_GEN_LSB = 1;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] CNT_TOP = 16'hffff;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ===== hw/fast_compare_channel.sv
/*
  One compare-timer channel: shadow compare value, active latch and output.
  Assumes count, tick and overflow come from the compare timer in the top.
*/
`timescale 1ns/1ps
`default_nettype none
module fast_compare_channel (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wr_low_i,
  input wire logic wr_high_i,
  input wire logic [7:0] wdata_i,
  input wire logic [15:0] count_i,
  input wire logic tick_i,
  input wire logic ovf_i,
  input wire logic assigned_i,
  output logic [15:0] value_o,
  output logic pwm_o
);
  import compare_pwm_pkg::*;
  typedef struct packed {
    logic [15:0] shadow;
    logic [15:0] active;
    logic out;
  } chan_t;
  chan_t r;
  chan_t n;

  always_comb begin
    n = r;
    if (wr_low_i) begin
      n.shadow[7:0] = wdata_i;
    end
    if (wr_high_i) begin
      n.shadow[15:8] = wdata_i;
    end
    if (ovf_i) begin
      n.active = r.shadow;
    end
    if (!assigned_i) begin
      n.out = 1'b0;
    end else if (ovf_i) begin
      n.out = 1'b0;
    end else if (tick_i && count_i == r.active) begin
      n.out = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign value_o = r.shadow;
  assign pwm_o = r.out;
endmodule // fast_compare_channel
`default_nettype wire

// ===== hw/compare_pwm_unit.sv
/*
  Compare/PWM unit: general 16-bit timer with two compare channels,
  prescaled compare timer with reload and eight compare channels,
  request flags, reached over AXI4-Lite.
  Assumes one clock equal to the machine cycle (oscillator divided by 2).
*/
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
// Summary of operation
// - Mode 0 outputs fall on timer overflow
// - Mode 1 edges set only by software
// - Mode 1 match copies port latch to pin
// - Enabled channel match sets interrupt request
// - Each general channel keeps its own request flag
// - General timer counts full 0 to ffff range
// - Eight prescaler rates, divide 2 to 256
// - Divide-by-2 increments every machine cycle
// - Compare timer restarts from reload after overflow
// - Fast mode 0: fall at overflow, rise at match
// - Assign bit puts channel on compare timer
// - Compare registers 16 bits as two bytes
// - Reload held in two writable byte registers
// - Compare timer serves eight channels at once
// - New compare value taken at next overflow
// - Pin driven only when compare enable set
// - Overflow request gated by own and global enable
`timescale 1ns/1ps
`default_nettype none
module compare_pwm_unit (
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  input wire logic AXI_AWVALID_I,
  output logic AXI_AWREADY_O,
  input wire logic [compare_pwm_pkg::ADDR_W-1:0] AXI_AWADDR_I,
  input wire logic AXI_WVALID_I,
  output logic AXI_WREADY_O,
  input wire logic [31:0] AXI_WDATA_I,
  input wire logic [3:0] AXI_WSTRB_I,
  output logic AXI_BVALID_O,
  input wire logic AXI_BREADY_I,
  output logic [1:0] AXI_BRESP_O,
  input wire logic AXI_ARVALID_I,
  output logic AXI_ARREADY_O,
  input wire logic [compare_pwm_pkg::ADDR_W-1:0] AXI_ARADDR_I,
  output logic AXI_RVALID_O,
  input wire logic AXI_RREADY_I,
  output logic [31:0] AXI_RDATA_O,
  output logic [1:0] AXI_RRESP_O,
  output logic [compare_pwm_pkg::FAST_CH-1:0] FAST_PWM_O,
  output logic [compare_pwm_pkg::FAST_CH-1:0] FAST_PWM_OE_O,
  output logic [compare_pwm_pkg::GEN_CH-1:0] GEN_PWM_O,
  output logic COMPARE_IRQ_LINE_A_O,
  output logic COMPARE_IRQ_LINE_B_O,
  output logic CT_IRQ_O
);
  import compare_pwm_pkg::*;

  typedef struct packed {
    logic awready;
    logic wready;
    logic arready;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [7:0] w_data;
    logic w_strb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [7:0] control;
    logic [7:0] compare_timer_assign;
    logic [7:0] fast_compare_output_enable;
    logic [15:0] compare_timer_reload;
    logic [7:0] gen_cfg;
    logic [2:0] flags;
    logic [1:0][15:0] general_compare;
    logic [PRE_W-1:0] pre;
    logic [15:0] ct;
    logic [15:0] gt;
    logic [1:0] gen_out;
    logic [7:0] fast_oe;
    logic ct_irq;
  } unit_t;

  unit_t r;
  unit_t n;

  logic [FAST_CH-1:0] fast_wr_low;
  logic [FAST_CH-1:0] fast_wr_high;
  logic [FAST_CH-1:0][15:0] fast_value;
  logic [FAST_CH-1:0] fast_pwm;
  logic [PRE_W-1:0] pre_mask;
  logic ct_tick;
  logic ct_ovf;
  logic gt_ovf;
  logic do_write;
  logic [7:0] wa;

  // Compare timer prescaler: select s gives one tick per 2^s machine cycles
  assign pre_mask = PRE_W'((8'h01 << r.control[CTL_PRESCALE_LSB +: 3]) - 8'h01);
  assign ct_tick = r.control[CTL_CT_RUN] && ((r.pre & pre_mask) == pre_mask);
  assign ct_ovf = ct_tick && (r.ct == CNT_TOP);
  assign gt_ovf = r.control[CTL_GT_RUN] && (r.gt == CNT_TOP);
  assign do_write = r.aw_held && r.w_held && !r.bvalid;
  assign wa = r.aw_addr;

  always_comb begin
    for (int i = 0; i < FAST_CH; i++) begin
      fast_wr_low[i] = do_write && r.w_strb0 && (wa == OFF_FAST_BASE + 8'(8 * i));
      fast_wr_high[i] = do_write && r.w_strb0 && (wa == OFF_FAST_BASE + 8'(8 * i + 4));
    end
  end

  for (genvar g = 0; g < FAST_CH; g++) begin : g_fast
    fast_compare_channel u_chan (
      .clk_i(CORE_CLK_I),
      .rst_n_i(RST_N_I),
      .wr_low_i(fast_wr_low[g]),
      .wr_high_i(fast_wr_high[g]),
      .wdata_i(r.w_data),
      .count_i(r.ct),
      .tick_i(ct_tick),
      .ovf_i(ct_ovf),
      .assigned_i(r.compare_timer_assign[g]),
      .value_o(fast_value[g]),
      .pwm_o(fast_pwm[g])
    );
  end

  always_comb begin
    logic [2:0] set_flags;
    logic [2:0] clr_flags;
    logic match;
    logic rd_ok;
    logic [31:0] rd;
    logic [7:0] ra;
    logic wr_ok;
    set_flags = 3'b000;
    clr_flags = 3'b000;
    match = 1'b0;
    rd_ok = 1'b1;
    rd = 32'h0000_0000;
    ra = AXI_ARADDR_I;
    wr_ok = 1'b1;
    n = r;

    // Write address and data are taken independently, in either order
    if (AXI_AWVALID_I && r.awready) begin
      n.aw_held = 1'b1;
      n.aw_addr = AXI_AWADDR_I;
    end
    if (AXI_WVALID_I && r.wready) begin
      n.w_held = 1'b1;
      n.w_data = AXI_WDATA_I[7:0];
      n.w_strb0 = AXI_WSTRB_I[0];
    end
    if (r.bvalid && AXI_BREADY_I) begin
      n.bvalid = 1'b0;
    end
    if (do_write) begin
      case (wa)
        OFF_CONTROL: if (r.w_strb0) n.control = r.w_data;
        OFF_ASSIGN: if (r.w_strb0) n.compare_timer_assign = r.w_data;
        OFF_OUT_EN: if (r.w_strb0) n.fast_compare_output_enable = r.w_data;
        OFF_RELOAD_LOW: if (r.w_strb0) n.compare_timer_reload[7:0] = r.w_data;
        OFF_RELOAD_HIGH: if (r.w_strb0) n.compare_timer_reload[15:8] = r.w_data;
        OFF_GEN_CFG: if (r.w_strb0) n.gen_cfg = r.w_data;
        OFF_FLAGS: if (r.w_strb0) clr_flags = r.w_data[2:0];
        OFF_CT_COUNT, OFF_GT_COUNT: wr_ok = 1'b1;
        default: begin
          wr_ok = 1'b0;
          for (int i = 0; i < GEN_CH; i++) begin
            if (wa == OFF_GC_BASE + 8'(8 * i)) begin
              wr_ok = 1'b1;
              if (r.w_strb0) n.general_compare[i][7:0] = r.w_data;
            end
            if (wa == OFF_GC_BASE + 8'(8 * i + 4)) begin
              wr_ok = 1'b1;
              if (r.w_strb0) n.general_compare[i][15:8] = r.w_data;
            end
          end
          for (int i = 0; i < FAST_CH; i++) begin
            if (wa == OFF_FAST_BASE + 8'(8 * i) || wa == OFF_FAST_BASE + 8'(8 * i + 4)) begin
              wr_ok = 1'b1;
            end
          end
        end
      endcase
      n.aw_held = 1'b0;
      n.w_held = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    n.awready = !n.aw_held && !n.bvalid;
    n.wready = !n.w_held && !n.bvalid;

    // Read channel
    if (r.rvalid && AXI_RREADY_I) begin
      n.rvalid = 1'b0;
    end
    if (AXI_ARVALID_I && r.arready) begin
      case (ra)
        OFF_CONTROL: rd[7:0] = r.control;
        OFF_ASSIGN: rd[7:0] = r.compare_timer_assign;
        OFF_OUT_EN: rd[7:0] = r.fast_compare_output_enable;
        OFF_RELOAD_LOW: rd[7:0] = r.compare_timer_reload[7:0];
        OFF_RELOAD_HIGH: rd[7:0] = r.compare_timer_reload[15:8];
        OFF_CT_COUNT: rd[15:0] = r.ct;
        OFF_GT_COUNT: rd[15:0] = r.gt;
        OFF_GEN_CFG: rd[7:0] = r.gen_cfg;
        OFF_FLAGS: rd[2:0] = r.flags;
        default: begin
          rd_ok = 1'b0;
          for (int i = 0; i < GEN_CH; i++) begin
            if (ra == OFF_GC_BASE + 8'(8 * i)) begin
              rd_ok = 1'b1;
              rd[7:0] = r.general_compare[i][7:0];
            end
            if (ra == OFF_GC_BASE + 8'(8 * i + 4)) begin
              rd_ok = 1'b1;
              rd[7:0] = r.general_compare[i][15:8];
            end
          end
          for (int i = 0; i < FAST_CH; i++) begin
            if (ra == OFF_FAST_BASE + 8'(8 * i)) begin
              rd_ok = 1'b1;
              rd[7:0] = fast_value[i][7:0];
            end
            if (ra == OFF_FAST_BASE + 8'(8 * i + 4)) begin
              rd_ok = 1'b1;
              rd[7:0] = fast_value[i][15:8];
            end
          end
        end
      endcase
      n.rvalid = 1'b1;
      n.rdata = rd;
      n.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    n.arready = !n.rvalid;

    // Compare timer: prescaler and counter with reload
    n.pre = r.control[CTL_CT_RUN] ? r.pre + PRE_W'(1) : '0;
    if (ct_tick) begin
      n.ct = ct_ovf ? r.compare_timer_reload : r.ct + 16'h0001;
    end
    set_flags[FLAG_CT_OVF] = ct_ovf;

    // General timer and its channels
    if (r.control[CTL_GT_RUN]) begin
      n.gt = r.gt + 16'h0001;
    end
    for (int i = 0; i < GEN_CH; i++) begin
      match = r.control[CTL_GT_RUN] && (r.gt == r.general_compare[i]);
      if (!r.gen_cfg[GEN_MODE_LSB + i]) begin
        if (gt_ovf) begin
          n.gen_out[i] = 1'b0;
        end else if (match) begin
          n.gen_out[i] = 1'b1;
        end
      end else if (match) begin
        n.gen_out[i] = r.gen_cfg[GEN_LATCH_LSB + i];
      end
      if (match && r.gen_cfg[GEN_IRQ_EN_LSB + i]) begin
        set_flags[FLAG_GEN_LSB + i] = 1'b1;
      end
    end

    // A flag set in the same cycle as its clear stays set
    n.flags = (r.flags & ~clr_flags) | set_flags;
    n.ct_irq = n.flags[FLAG_CT_OVF] && n.control[CTL_CT_IRQ_EN]
               && n.control[CTL_GLOBAL_IRQ_EN];
    n.fast_oe = n.fast_compare_output_enable & n.compare_timer_assign;
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign AXI_AWREADY_O = r.awready;
  assign AXI_WREADY_O = r.wready;
  assign AXI_BVALID_O = r.bvalid;
  assign AXI_BRESP_O = r.bresp;
  assign AXI_ARREADY_O = r.arready;
  assign AXI_RVALID_O = r.rvalid;
  assign AXI_RDATA_O = r.rdata;
  assign AXI_RRESP_O = r.rresp;
  assign FAST_PWM_O = fast_pwm;
  assign FAST_PWM_OE_O = r.fast_oe;
  assign GEN_PWM_O = r.gen_out;
  assign COMPARE_IRQ_LINE_A_O = r.flags[FLAG_GEN_LSB];
  assign COMPARE_IRQ_LINE_B_O = r.flags[FLAG_GEN_LSB + 1];
  assign CT_IRQ_O = r.ct_irq;
endmodule // compare_pwm_unit
`default_nettype wire

// ===== testbench/compare_pwm_unit_assertions.sv
/*
  Checker for the compare/PWM unit: bus handshakes, reset state, outputs.
  Bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module compare_pwm_unit_assertions (
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  input wire logic AXI_AWVALID_I,
  input wire logic AXI_AWREADY_O,
  input wire logic AXI_WVALID_I,
  input wire logic AXI_WREADY_O,
  input wire logic AXI_BVALID_O,
  input wire logic AXI_BREADY_I,
  input wire logic AXI_ARVALID_I,
  input wire logic AXI_ARREADY_O,
  input wire logic AXI_RVALID_O,
  input wire logic AXI_RREADY_I,
  input wire logic [compare_pwm_pkg::FAST_CH-1:0] FAST_PWM_O,
  input wire logic [compare_pwm_pkg::FAST_CH-1:0] FAST_PWM_OE_O,
  input wire logic COMPARE_IRQ_LINE_A_O,
  input wire logic CT_IRQ_O
);
  import compare_pwm_pkg::*;
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);
  sequence s_wr_taken;
    AXI_AWVALID_I && AXI_AWREADY_O && AXI_WVALID_I && AXI_WREADY_O;
  endsequence
  sequence s_rd_taken;
    AXI_ARVALID_I && AXI_ARREADY_O;
  endsequence
  a_write_answer: assert property (s_wr_taken |-> ##[1:2] AXI_BVALID_O)
    else $error("write not answered");
  a_read_answer: assert property (s_rd_taken |=> AXI_RVALID_O)
    else $error("read not answered");
  a_bvalid_hold: assert property (AXI_BVALID_O && !AXI_BREADY_I |=> AXI_BVALID_O)
    else $error("write response dropped");
  a_rvalid_hold: assert property (AXI_RVALID_O && !AXI_RREADY_I |=> AXI_RVALID_O)
    else $error("read response dropped");
  a_read_refused: assert property (AXI_RVALID_O |-> !AXI_ARREADY_O)
    else $error("read address taken while busy");
  a_write_refused: assert property (AXI_BVALID_O |-> !AXI_AWREADY_O && !AXI_WREADY_O)
    else $error("write taken while busy");
  a_reset_quiet: assert property ($rose(RST_N_I) |->
    FAST_PWM_O == '0 && FAST_PWM_OE_O == '0 && !CT_IRQ_O && !COMPARE_IRQ_LINE_A_O)
    else $error("outputs active after reset");
  a_fall_together: assert property (
    ($past(FAST_PWM_O) & ~FAST_PWM_O) != '0 |-> FAST_PWM_O == '0)
    else $error("fast outputs did not fall together");
  a_flag_sticky: assert property ($fell(COMPARE_IRQ_LINE_A_O) |->
    $past(AXI_WVALID_I) || $past(AXI_WVALID_I, 2) || $past(AXI_WVALID_I, 3))
    else $error("request flag cleared without a write");
endmodule // compare_pwm_unit_assertions
bind compare_pwm_unit compare_pwm_unit_assertions u_compare_pwm_unit_assertions (.*);
`default_nettype wire

// ===== testbench/pin_load_model.sv
/*
  Port pins of the fast compare channels feeding external filters.
  Assumes a released pin is pulled up by its ordinary port function.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_load_model (
  input wire logic [7:0] pwm_i,
  input wire logic [7:0] oe_i,
  output logic [7:0] pin_o
);
  // Undriven pins sit at the pull-up level
  assign pin_o = (pwm_i & oe_i) | ~oe_i;
endmodule // pin_load_model
`default_nettype wire

// ===== testbench/test_compare_pwm_unit.sv
/*
  Self-checking bench for the compare/PWM unit over AXI4-Lite.
  Assumes a 200 MHz clock and the port pin load model.
*/
`timescale 1ns/1ps
`default_nettype none
module test_compare_pwm_unit;
  import compare_pwm_pkg::*;
  localparam logic [7:0] ZERO_OFF [4] = '{OFF_CONTROL, OFF_OUT_EN, OFF_FLAGS, OFF_CT_COUNT};
  logic clk;
  logic rst_n = 1'h0;
  logic awv = 1'h0, wv = 1'h0, bre = 1'h0, arv = 1'h0, rre = 1'h0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdat;
  logic awr, wrd, bv, arr, rv, ia, ib, cti;
  logic [1:0] br, rr, gp;
  logic [7:0] fp, foe, pin;
  int err_total = 0;
  int n_compared = 0;
  compare_pwm_unit u_compare_pwm_unit (
    .CORE_CLK_I(clk), .RST_N_I(rst_n), .AXI_AWVALID_I(awv), .AXI_AWREADY_O(awr),
    .AXI_AWADDR_I(awa), .AXI_WVALID_I(wv), .AXI_WREADY_O(wrd), .AXI_WDATA_I(wd),
    .AXI_WSTRB_I(4'hf), .AXI_BVALID_O(bv), .AXI_BREADY_I(bre), .AXI_BRESP_O(br),
    .AXI_ARVALID_I(arv), .AXI_ARREADY_O(arr), .AXI_ARADDR_I(ara), .AXI_RVALID_O(rv),
    .AXI_RREADY_I(rre), .AXI_RDATA_O(rdat), .AXI_RRESP_O(rr), .FAST_PWM_O(fp),
    .FAST_PWM_OE_O(foe), .GEN_PWM_O(gp), .COMPARE_IRQ_LINE_A_O(ia),
    .COMPARE_IRQ_LINE_B_O(ib), .CT_IRQ_O(cti));
  pin_load_model u_pin_load_model (.pwm_i(fp), .oe_i(foe), .pin_o(pin));
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
    logic ga, gw;
    ga = 1'h0;
    gw = 1'h0;
    @(posedge clk);
    awv <= 1'h1; wv <= 1'h1; awa <= a; wd <= {24'h0, d}; bre <= 1'h1;
    while (!(ga && gw)) begin
      @(negedge clk);
      ga = ga | awr;
      gw = gw | wrd;
      @(posedge clk);
      if (ga) awv <= 1'h0;
      if (gw) wv <= 1'h0;
    end
    do begin
      @(negedge clk);
      ga = bv;
      gw = (br === er);
      @(posedge clk);
    end while (!ga);
    bre <= 1'h0;
    check(gw, 1'h1);
    @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = RESP_OKAY);
    logic g;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk);
    arv <= 1'h1; ara <= a; rre <= 1'h1;
    do begin @(negedge clk); g = arr; @(posedge clk); end while (!g);
    arv <= 1'h0;
    do begin @(negedge clk); g = rv; d = rdat; r = rr; @(posedge clk); end while (!g);
    rre <= 1'h0;
    check(d, exp);
    check(r, er);
    @(negedge clk);
  endtask
  // Period and high time of fast channel 0 as seen on its pin
  task automatic measure(output int hi, output int per);
    hi = 0;
    while (pin[0]) @(negedge clk);
    while (!pin[0]) @(negedge clk);
    while (pin[0]) begin hi++; @(negedge clk); end
    per = hi;
    while (!pin[0]) begin per++; @(negedge clk); end
  endtask
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #500000;
    err_total++;
    final_report();
  end
  initial begin
    int h0, h1, p;
    time t0;
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    foreach (ZERO_OFF[i]) rd(ZERO_OFF[i], 32'h0);
    check(pin, 8'hff);
    rd(8'hfc, 32'h0, RESP_SLVERR);
    wr(8'hfc, 8'h55, RESP_SLVERR);
    wr(OFF_RELOAD_LOW, 8'h00);
    wr(OFF_RELOAD_HIGH, 8'hff);
    rd(OFF_RELOAD_HIGH, 32'hff);
    wr(OFF_FAST_BASE, 8'h80);
    wr(OFF_FAST_BASE + 8'h04, 8'hff);
    rd(OFF_FAST_BASE + 8'h04, 32'hff);
    wr(OFF_GC_BASE, 8'h00);
    wr(OFF_GC_BASE + 8'h04, 8'h01);
    wr(OFF_GC_BASE + 8'h0c, 8'h80);
    wr(OFF_GEN_CFG, 8'h1d);
    wr(OFF_ASSIGN, 8'h01);
    wr(OFF_OUT_EN, 8'h01);
    // Both timers start together so that their long first periods overlap
    wr(OFF_CONTROL, 8'h48);
    check(foe, 8'h01);
    while (!gp[0]) @(negedge clk);
    t0 = $time;
    check(ia, 1'h1);
    check(ib, 1'h0);
    wr(OFF_FLAGS, 8'h02);
    wr(OFF_GEN_CFG, 8'h0d);
    check(ia, 1'h0);
    check(gp[0], 1'h1);
    fork
      begin
        while (!gp[1]) @(negedge clk);
        check(ib, 1'h1);
        while (gp[1]) @(negedge clk);
        check(32'(($time - t0) / 5), 32'h0000_feff);
        while (gp[0]) @(negedge clk);
        check(32'(($time - t0) / 5), 65536);
        check(gp[1], 1'h0);
      end
      begin
        measure(h0, p);
        check(p, 256);
        check(cti, 1'h0);
        wr(OFF_CONTROL, 8'h58);
        check(cti, 1'h0);
        wr(OFF_CONTROL, 8'h78);
        repeat (3) @(negedge clk);
        check(cti, 1'h1);
        while (pin[0]) @(negedge clk);
        wr(OFF_FAST_BASE, 8'h40);
        measure(h1, p);
        check(h1, h0);
        measure(h1, p);
        check(h1, h0 + 64);
        wr(OFF_RELOAD_LOW, 8'hf0);
        for (int n = 0; n < 8; n++) begin
          wr(OFF_FAST_BASE + 8'(8 * n), 8'hf0 + 8'(n));
          wr(OFF_FAST_BASE + 8'(8 * n + 4), 8'hff);
        end
        wr(OFF_ASSIGN, 8'hff);
        check(foe, 8'h01);
        for (int s = 0; s < 8; s++) begin
          wr(OFF_CONTROL, 8'h48 | 8'(s));
          measure(h1, p);
          check(p, 16 << s);
        end
        while (!fp[7]) @(negedge clk);
        check(fp, 8'hff);
        check(pin[7:1], 7'h7f);
      end
    join
    final_report();
  end
endmodule // test_compare_pwm_unit
`default_nettype wire
